/* File: logic/hbd_dma_master.sv */
// module: system-side bus-master dma write sequencer, intel-style bus mode
module hbd_dma_master
    import hbd_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // job control
    input  wire logic              startReq,
    input  wire logic [ADDR_W-1:0] startAddr,
    input  wire logic [LEN_W-1:0]  startLen,
    input  wire logic              burstMode,
    input  wire logic              narrowBus,
    input  wire logic [RETRY_W-1:0] errorRetryCount,
    input  wire logic              haltClear,
    // write data stream
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic              wrValid,
    output logic                   wrReady,
    // status
    output logic                   jobBusy,
    output logic                   jobDone,
    output logic                   dmaHalted,
    output logic                   localDmaHalt,
    output logic [ADDR_W-1:0]      curAddr,
    output logic [LEN_W-1:0]       curLen,
    // arbitration
    output logic                   holdRequestOut,
    input  wire logic              holdAckIn,
    input  wire logic              busReleaseRequestN,
    output logic                   busOwnedN,
    output logic                   dataDirectionOut,
    // bus cycle
    output logic                   systemBusClock,
    input  wire logic              systemReadyInN,
    input  wire logic              busErrorInN,
    output logic                   addressLatchStrobe,
    output logic                   extAddressLatchStrobe,
    output logic                   writeStrobeN,
    output logic                   readStrobeN,
    output logic                   strobeOe,
    output logic                   dataBufferEnableN,
    output logic [BYTE_W-1:0]      addrDataHighOut,
    output logic [BYTE_W-1:0]      addrDataLowOut,
    output logic                   addrDataOe,
    output logic                   parityHighOut,
    output logic                   parityLowOut,
    output logic                   parityOe,
    output logic                   highByteEnableN,
    // slave select gating
    input  wire logic              slaveSelectN,
    output logic                   slaveSelectGated
);

    // ==========================================
    // state record
    typedef struct packed {
        hbd_state_e         st;
        logic               ph;
        logic               go;
        logic [ADDR_W-1:0]  addr;
        logic [LEN_W-1:0]   len;
        logic [RETRY_W-1:0] retries;
        logic [DATA_W-1:0]  data;
        logic               needTx;
        logic               relPend;
        logic               errSeen;
        logic               halted;
        logic               done;
        logic [SYNC_W-1:0]  rdySh;
        logic [SYNC_W-1:0]  rlsSh;
        logic [SYNC_W-1:0]  errSh;
        logic [SYNC_W-1:0]  ackSh;
        logic [SYNC_W-1:0]  selSh;
        logic               rdyF;
        logic               rlsF;
        logic               errF;
        logic               ackF;
        logic               selF;
        logic               hold;
        logic               ownedN;
        logic               dirOut;
        logic               ale;
        logic               xal;
        logic               wrN;
        logic               strbOe;
        logic               bufN;
        logic [BYTE_W-1:0]  adH;
        logic [BYTE_W-1:0]  adL;
        logic               adOe;
        logic               parH;
        logic               parL;
        logic               bheN;
    } hbd_regs_s;

    hbd_regs_s r_q;
    hbd_regs_s r_d;

    // ==========================================
    // helpers
    // a change counts once the second and third stages agree
    function automatic logic syncFilt(input logic [SYNC_W-1:0] sh, input logic prev);
        syncFilt = (sh[1] == sh[2]) ? sh[2] : prev;
    endfunction

    // odd parity over one byte
    function automatic logic oddPar(input logic [BYTE_W-1:0] b);
        oddPar = ~(^b);
    endfunction

    function automatic logic inCycle(input hbd_state_e s);
        inCycle = (s == S_TX) || (s == S_T1) || (s == S_T2) || (s == S_T3) || (s == S_T4);
    endfunction

    logic              owned;
    logic              takeWord;
    logic [LOW_W:0]    lowSum;
    logic              dataPhase;

    // ==========================================
    // next state
    always_comb begin
        r_d = r_q;
        r_d.ph = ~r_q.ph;
        r_d.done = 1'b0;

        r_d.rdySh = {r_q.rdySh[1:0], systemReadyInN};
        r_d.rlsSh = {r_q.rlsSh[1:0], busReleaseRequestN};
        r_d.errSh = {r_q.errSh[1:0], busErrorInN};
        r_d.ackSh = {r_q.ackSh[1:0], holdAckIn};
        r_d.selSh = {r_q.selSh[1:0], slaveSelectN};
        r_d.rdyF = syncFilt(r_q.rdySh, r_q.rdyF);
        r_d.rlsF = syncFilt(r_q.rlsSh, r_q.rlsF);
        r_d.errF = syncFilt(r_q.errSh, r_q.errF);
        r_d.ackF = syncFilt(r_q.ackSh, r_q.ackF);
        r_d.selF = syncFilt(r_q.selSh, r_q.selF);

        owned = (r_q.st == S_WAIT) || inCycle(r_q.st) || (r_q.st == S_I1);
        lowSum = {1'b0, r_q.addr[LOW_W-1:0]} + (narrowBus ? STEP_NARROW : STEP_WIDE);
        takeWord = (r_q.st == S_WAIT) && (r_q.ph == PH_LOW) && !r_q.relPend
                   && (r_q.len != LEN_ZERO) && r_q.go;

        // release only counts while this end owns the bus
        if (!r_q.rlsF && owned) begin
            r_d.relPend = 1'b1;
        end
        // error sampled only while waiting in T3: earlier states may still see
        // a stale error in the synchroniser, raised while outside the cycle
        if (!r_q.errF && (r_q.st == S_T3)) begin
            r_d.errSeen = 1'b1;
        end

        if (haltClear && r_q.st == S_IDLE) begin
            r_d.halted = 1'b0;
        end

        if (startReq && r_q.st == S_IDLE && !r_q.go) begin
            r_d.go = startLen != LEN_ZERO;
            r_d.addr = startAddr;
            r_d.len = startLen;
            r_d.retries = errorRetryCount;
            r_d.needTx = 1'b1;
        end

        if (takeWord) begin
            r_d.data = wrData;
        end

        if (r_q.ph == PH_LOW) begin
            unique case (r_q.st)
                S_IDLE: begin
                    if (r_q.go && !r_q.halted) begin
                        r_d.st = S_REQ;
                    end
                end
                S_REQ: begin
                    if (r_q.ackF) begin
                        r_d.st = S_WAIT;
                    end
                end
                S_WAIT: begin
                    // no transfer started yet: a release goes out first
                    if (r_q.relPend || !r_q.go) begin
                        r_d.st = S_I1;
                    end else if (wrValid) begin
                        r_d.st = r_q.needTx ? S_TX : S_T1;
                    end
                end
                S_TX: r_d.st = S_T1;
                S_T1: r_d.st = S_T2;
                S_T2: r_d.st = S_T3;
                S_T3: begin
                    // an error ends the wait whatever ready says
                    if (!r_q.rdyF || r_q.errSeen || !r_q.errF) begin
                        r_d.st = S_T4;
                    end
                end
                S_T4: begin
                    r_d.errSeen = 1'b0;
                    if (r_q.errSeen) begin
                        if (r_q.retries != RETRY_ZERO) begin
                            r_d.retries = r_q.retries - RETRY_ONE;
                            r_d.needTx = 1'b1;
                            r_d.st = S_TX;
                        end else begin
                            // address and length left as they stand
                            r_d.halted = 1'b1;
                            r_d.go = 1'b0;
                            r_d.st = S_I1;
                        end
                    end else begin
                        r_d.addr = {r_q.addr[ADDR_W-1:LOW_W] + {{(ADDR_W-LOW_W-1){1'b0}}, lowSum[LOW_W]},
                                    lowSum[LOW_W-1:0]};
                        r_d.len = r_q.len - LEN_ONE;
                        r_d.needTx = !burstMode || lowSum[LOW_W];
                        r_d.retries = errorRetryCount;
                        if (r_q.len == LEN_ONE) begin
                            r_d.go = 1'b0;
                            r_d.done = 1'b1;
                        end
                        // a cycle already begun is always finished first
                        if (!burstMode || r_q.relPend || r_q.len == LEN_ONE) begin
                            r_d.st = S_I1;
                        end else begin
                            r_d.st = S_WAIT;
                        end
                    end
                end
                S_I1: r_d.st = S_I2;
                S_I2: begin
                    r_d.st = S_IDLE;
                    r_d.relPend = 1'b0;
                end
            endcase
        end

        // ==========================================
        // pin values follow the next state so they change on its edge
        dataPhase = ((r_d.st == S_T2) && (r_d.ph == PH_LOW)) || (r_d.st == S_T3) || (r_d.st == S_T4);
        r_d.hold = (r_d.st == S_REQ) || (r_d.st == S_WAIT) || inCycle(r_d.st);
        r_d.ownedN = !((r_d.st == S_WAIT) || inCycle(r_d.st) || (r_d.st == S_I1)
                       || ((r_d.st == S_I2) && (r_d.ph == PH_HIGH)));
        r_d.dirOut = r_d.ownedN;
        r_d.xal = (r_d.st == S_TX) && (r_d.ph == PH_HIGH);
        r_d.ale = (r_d.st == S_T1) && (r_d.ph == PH_HIGH);
        r_d.wrN = !(dataPhase && !((r_d.st == S_T4) && (r_d.ph == PH_LOW)));
        r_d.strbOe = (r_d.st == S_WAIT) || inCycle(r_d.st);
        r_d.bufN = !((r_d.st == S_T1) || (r_d.st == S_T2) || (r_d.st == S_T3));
        r_d.adOe = inCycle(r_d.st);
        r_d.bheN = narrowBus;
        if (r_d.st == S_TX) begin
            r_d.adH = r_d.addr[ADDR_W-1:ADDR_W-BYTE_W];
            r_d.adL = r_d.addr[ADDR_W-BYTE_W-1:LOW_W];
        end else if (!inCycle(r_d.st) || !dataPhase) begin
            r_d.adH = r_d.addr[LOW_W-1:BYTE_W];
            r_d.adL = r_d.addr[BYTE_W-1:0];
        end else if (narrowBus) begin
            r_d.adH = r_d.addr[LOW_W-1:BYTE_W];
            r_d.adL = r_d.data[BYTE_W-1:0];
        end else begin
            r_d.adH = r_d.data[DATA_W-1:BYTE_W];
            r_d.adL = r_d.data[BYTE_W-1:0];
        end
        r_d.parH = oddPar(r_d.adH);
        r_d.parL = oddPar(r_d.adL);

        if (!rst_n) begin
            r_d = '0;
            r_d.st = S_IDLE;
            r_d.ph = PH_HIGH;
            r_d.rdySh = SYNC_IDLE;
            r_d.rlsSh = SYNC_IDLE;
            r_d.errSh = SYNC_IDLE;
            r_d.selSh = SYNC_IDLE;
            r_d.rdyF = 1'b1;
            r_d.rlsF = 1'b1;
            r_d.errF = 1'b1;
            r_d.ackF = 1'b0;
            r_d.selF = 1'b1;
            r_d.ownedN = 1'b1;
            r_d.dirOut = 1'b1;
            r_d.wrN = 1'b1;
            r_d.bufN = 1'b1;
            r_d.bheN = 1'b1;
        end
    end

    // ==========================================
    // register; every pin value holds until the next edge
    always_ff @(posedge clk) begin
        r_q <= r_d;
    end

    // ==========================================
    // outputs
    // acknowledge is looked at only in REQ, not on release: the slave drops it on its own
    assign wrReady = takeWord;
    assign jobBusy = r_q.go || (r_q.st != S_IDLE);
    assign jobDone = r_q.done;
    assign dmaHalted = r_q.halted;
    assign localDmaHalt = r_q.halted;
    assign curAddr = r_q.addr;
    assign curLen = r_q.len;
    assign holdRequestOut = r_q.hold;
    assign busOwnedN = r_q.ownedN;
    assign dataDirectionOut = r_q.dirOut;
    assign systemBusClock = ~r_q.ph;
    assign addressLatchStrobe = r_q.ale;
    assign extAddressLatchStrobe = r_q.xal;
    assign writeStrobeN = r_q.wrN;
    assign readStrobeN = r_q.wrN | r_q.bufN | 1'b1;
    assign strobeOe = r_q.strbOe;
    assign dataBufferEnableN = r_q.bufN;
    assign addrDataHighOut = r_q.adH;
    assign addrDataLowOut = r_q.adL;
    assign addrDataOe = r_q.adOe;
    assign parityHighOut = r_q.parH;
    assign parityLowOut = r_q.parL;
    assign parityOe = r_q.adOe;
    assign highByteEnableN = r_q.bheN;
    // host slave access is shut out while this end drives the bus
    assign slaveSelectGated = r_q.ownedN & ~r_q.selF;

endmodule

/* File: logic/hbd_pkg.sv */
// package: constants and types for the host-bus dma write sequencer
package hbd_pkg;

    // ==========================================
    // widths
    localparam int ADDR_W  = 32;
    localparam int LOW_W   = 16;
    localparam int LEN_W   = 16;
    localparam int DATA_W  = 16;
    localparam int BYTE_W  = 8;
    localparam int RETRY_W = 8;
    localparam int SYNC_W  = 3;

    // ==========================================
    // address steps and phase codes
    localparam logic [LOW_W:0]   STEP_WIDE   = 17'h0_0002;
    localparam logic [LOW_W:0]   STEP_NARROW = 17'h0_0001;
    localparam logic             PH_HIGH     = 1'b0;
    localparam logic             PH_LOW      = 1'b1;
    localparam logic [LEN_W-1:0] LEN_ONE     = 16'h0001;
    localparam logic [LEN_W-1:0] LEN_ZERO    = 16'h0000;
    localparam logic [RETRY_W-1:0] RETRY_ONE = 8'h01;
    localparam logic [RETRY_W-1:0] RETRY_ZERO = 8'h00;
    localparam logic [SYNC_W-1:0]  SYNC_IDLE  = 3'h7;

    // ==========================================
    // bus states
    typedef enum logic [3:0] {
        S_IDLE,
        S_REQ,
        S_WAIT,
        S_TX,
        S_T1,
        S_T2,
        S_T3,
        S_T4,
        S_I1,
        S_I2
    } hbd_state_e;

endpackage

/* File: verification/hbd_dma_master_sva.sv */
// checker: bus sequencing properties of the dma write sequencer
module hbd_dma_master_sva
    import hbd_pkg::*;
(
    // clock, reset, mode
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              burstMode,
    input wire logic              narrowBus,
    // status and arbitration
    input wire logic              dmaHalted,
    input wire logic              localDmaHalt,
    input wire logic              holdRequestOut,
    input wire logic              busOwnedN,
    input wire logic              dataDirectionOut,
    input wire logic              slaveSelectGated,
    // bus cycle
    input wire logic              addressLatchStrobe,
    input wire logic              extAddressLatchStrobe,
    input wire logic              writeStrobeN,
    input wire logic              strobeOe,
    input wire logic              dataBufferEnableN,
    input wire logic [BYTE_W-1:0] addrDataHighOut,
    input wire logic [BYTE_W-1:0] addrDataLowOut,
    input wire logic              addrDataOe,
    input wire logic              parityHighOut,
    input wire logic              parityLowOut,
    input wire logic              parityOe,
    input wire logic              highByteEnableN
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // properties
    property p_ss; !busOwnedN |-> !slaveSelectGated; endproperty
    a_ss: assert property (p_ss) else $error("slave select passed while owner");
    property p_bhe; strobeOe && narrowBus |-> highByteEnableN; endproperty
    a_bhe: assert property (p_bhe) else $error("byte enable low in narrow mode");
    property p_xal; $rose(extAddressLatchStrobe) |-> addrDataOe ##1 !extAddressLatchStrobe; endproperty
    a_xal: assert property (p_xal) else $error("extended latch strobe width");
    property p_ale; $rose(addressLatchStrobe) |-> addrDataOe && !dataBufferEnableN ##1 !addressLatchStrobe; endproperty
    a_ale: assert property (p_ale) else $error("latch strobe or buffer enable in T1");
    property p_wr; $rose(addressLatchStrobe) |-> ##3 $fell(writeStrobeN) && parityOe
        && parityLowOut == ~^addrDataLowOut && parityHighOut == ~^addrDataHighOut; endproperty
    a_wr: assert property (p_wr) else $error("write strobe or parity at T2");
    property p_buf; $rose(dataBufferEnableN) |-> !writeStrobeN ##1 writeStrobeN; endproperty
    a_buf: assert property (p_buf) else $error("buffer disable not in T4");
    property p_free; $fell(holdRequestOut) |-> !addrDataOe && !strobeOe && !parityOe && $past(dataBufferEnableN, 2)
        ##3 $rose(busOwnedN) && dataDirectionOut; endproperty
    a_free: assert property (p_free) else $error("bus hand back sequence");
    property p_steal; !burstMode && $rose(addressLatchStrobe) |-> $past(extAddressLatchStrobe, 2); endproperty
    a_steal: assert property (p_steal) else $error("cycle steal transfer without TX");
    property p_high; narrowBus && !writeStrobeN && !$past(writeStrobeN) |-> $stable(addrDataHighOut); endproperty
    a_high: assert property (p_high) else $error("high address byte moved");
    property p_halt; $rose(dmaHalted) |-> ##[0:3] localDmaHalt ##[0:16] busOwnedN && !holdRequestOut; endproperty
    a_halt: assert property (p_halt) else $error("halt not carried or bus kept");
endmodule

bind hbd_dma_master hbd_dma_master_sva u_sva (.clk, .rst_n, .burstMode, .narrowBus, .dmaHalted, .localDmaHalt,
    .holdRequestOut, .busOwnedN, .dataDirectionOut, .slaveSelectGated, .addressLatchStrobe,
    .extAddressLatchStrobe, .writeStrobeN, .strobeOe, .dataBufferEnableN, .addrDataHighOut,
    .addrDataLowOut, .addrDataOe, .parityHighOut, .parityLowOut, .parityOe, .highByteEnableN);

/* File: verification/hbd_bus_partner.sv */
// model: host bus arbiter and write slave facing the dma sequencer
module hbd_bus_partner (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // scenario controls
    input  wire logic slow,
    input  wire logic errNext,
    input  wire logic relReq,
    // device side
    input  wire logic holdRequestOut,
    input  wire logic busOwnedN,
    input  wire logic writeStrobeN,
    output logic      holdAckIn,
    output logic      systemReadyInN,
    output logic      busErrorInN,
    output logic      busReleaseRequestN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCnt;
    always @(posedge clk) begin
        if (!rst_n) begin
            {holdAckIn, waitCnt} <= 5'h00;
            {systemReadyInN, busErrorInN, busReleaseRequestN} <= 3'h7;
        end else begin
            holdAckIn <= holdRequestOut;
            if (writeStrobeN) begin
                waitCnt <= 4'h0;
                systemReadyInN <= 1'b1;
                // error also shown while not owner, which must be ignored
                busErrorInN <= !(errNext && busOwnedN);
            end else begin
                waitCnt <= waitCnt + 4'h1;
                if (waitCnt >= (slow ? 4'h6 : 4'h0)) begin
                    if (errNext || !busErrorInN) busErrorInN <= 1'b0;
                    else systemReadyInN <= 1'b0;
                end
            end
            busReleaseRequestN <= busReleaseRequestN ? !(relReq && !busOwnedN) : busOwnedN;
        end
    end
endmodule

/* File: verification/hbd_dma_master_tb.sv */
// testbench: random and corner write jobs through the dma sequencer
module hbd_dma_master_tb import hbd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, startReq, burstMode, narrowBus, haltClear, wrValid, slaveSelectN, slow, errNext, relReq;
    logic holdAckIn, systemReadyInN, busErrorInN, busReleaseRequestN, wrReady, jobBusy, jobDone, dmaHalted;
    logic localDmaHalt, holdRequestOut, busOwnedN, dataDirectionOut, systemBusClock, addressLatchStrobe;
    logic extAddressLatchStrobe, writeStrobeN, readStrobeN, strobeOe, dataBufferEnableN, addrDataOe;
    logic parityHighOut, parityLowOut, parityOe, highByteEnableN, slaveSelectGated, prevW, prevOwn, sawErr;
    logic [BYTE_W-1:0]  addrDataHighOut, addrDataLowOut;
    logic [ADDR_W-1:0]  startAddr, curAddr, ea, r;
    logic [LEN_W-1:0]   startLen, curLen;
    logic [RETRY_W-1:0] errorRetryCount;
    logic [DATA_W-1:0]  wrData, key, hiCap, loCap, dCap;
    int seed = 11983;
    int err_total, num_checks, cyc, taken, idx, txCnt, ownRise;

    hbd_dma_master uut (.clk, .rst_n, .startReq, .startAddr, .startLen, .burstMode, .narrowBus,
        .errorRetryCount, .haltClear, .wrData, .wrValid, .wrReady, .jobBusy, .jobDone, .dmaHalted,
        .localDmaHalt, .curAddr, .curLen, .holdRequestOut, .holdAckIn, .busReleaseRequestN, .busOwnedN,
        .dataDirectionOut, .systemBusClock, .systemReadyInN, .busErrorInN, .addressLatchStrobe,
        .extAddressLatchStrobe, .writeStrobeN, .readStrobeN, .strobeOe, .dataBufferEnableN, .addrDataHighOut,
        .addrDataLowOut, .addrDataOe, .parityHighOut, .parityLowOut, .parityOe, .highByteEnableN,
        .slaveSelectN, .slaveSelectGated);
    hbd_bus_partner u_bus (.clk, .rst_n, .slow, .errNext, .relReq, .holdRequestOut, .busOwnedN,
        .writeStrobeN, .holdAckIn, .systemReadyInN, .busErrorInN, .busReleaseRequestN);

    // ==========================================
    // expectations and reporting
    function automatic logic [31:0] addrOf(int i); return startAddr + (narrowBus ? 32'(i) : 32'(2 * i)); endfunction
    function automatic logic [15:0] wordOf(int i); return key + 16'(i) * 16'h1357; endfunction
    function automatic int expTx();
        int n = 1;
        for (int i = 1; i < int'(startLen); i++) if (addrOf(i) >> 16 !== addrOf(i - 1) >> 16) n++;
        return burstMode ? n : int'(startLen);
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (err_total == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================
    // clock, watchdog, stream and bus monitor
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            final_report();
        end
    end
    always @(negedge clk) begin
        wrData <= wordOf(taken);
        slaveSelectN <= 1'($random(seed));
    end
    always @(posedge clk) begin
        ea = addrOf(idx);
        if (wrValid && wrReady) taken++;
        if (extAddressLatchStrobe) begin
            hiCap = {addrDataHighOut, addrDataLowOut};
            txCnt++;
        end
        if (addressLatchStrobe) begin
            loCap = {addrDataHighOut, addrDataLowOut};
            chk(32'(systemBusClock), 32'h1);
        end
        if (!writeStrobeN) dCap = {addrDataHighOut, addrDataLowOut};
        if (!writeStrobeN && !busErrorInN) sawErr = 1'b1;
        if (prevW === 1'b0 && writeStrobeN === 1'b1) begin
            // a failed attempt is written again, so only clean ones advance
            if (!sawErr) begin
                chk({hiCap, loCap}, ea);
                chk(32'(dCap), narrowBus ? {ea[15:8], 8'(wordOf(idx))} : wordOf(idx));
                chk(32'(readStrobeN), 32'h1);
                idx++;
            end
            sawErr = 1'b0;
        end
        if (prevOwn === 1'b0 && busOwnedN === 1'b1) ownRise++;
        prevW = writeStrobeN;
        prevOwn = busOwnedN;
    end

    // ==========================================
    // one write job
    task automatic run(logic [31:0] a, logic [15:0] n, bit b, nb, logic [7:0] rc, bit sl, er, rl);
        int k;
        {startAddr, startLen, errorRetryCount} = {a, n, rc};
        {burstMode, narrowBus, slow, errNext, relReq} = {b, nb, sl, er, rl};
        key = 16'($random(seed));
        {taken, idx, txCnt, ownRise, sawErr} = 129'h0;
        startReq = 1'b1;
        @(negedge clk) startReq = 1'b0;
        for (k = 0; k < 600 && !jobDone && !dmaHalted; k++) begin
            @(negedge clk);
            if (!busErrorInN && !writeStrobeN) errNext = 1'b0;
            if (!busReleaseRequestN) relReq = 1'b0;
        end
        if (er && rc == 8'h00) chk(dmaHalted, 1);
        else begin
            chk({jobDone, dmaHalted, 16'(idx)}, {2'b10, n});
            chk(curAddr, addrOf(int'(n)));
            chk(32'(curLen), 32'h0);
        end
        for (k = 0; k < 60 && busOwnedN !== 1'b1; k++) @(negedge clk);
        for (k = 0; k < 60 && jobBusy !== 1'b0; k++) @(negedge clk);
        if (er && rc == 8'h00) begin
            chk({busOwnedN, localDmaHalt}, 2'b11);
            haltClear = 1'b1;
            repeat (2) @(negedge clk);
            haltClear = 1'b0;
            chk(dmaHalted, 0);
        end else if (!er) begin
            chk(rl ? 32'(ownRise >= 2) : 32'(ownRise), rl ? 1 : (b ? 1 : 32'(n)));
            if (!rl) chk(txCnt, expTx());
        end
    endtask

    initial begin
        {rst_n, startReq, haltClear, slow, errNext, relReq} = 6'h00;
        {startAddr, startLen, errorRetryCount, wrData} = 72'h0;
        {burstMode, narrowBus, wrValid, slaveSelectN} = 4'h3;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        run(32'h0001_FFFC, 16'h0004, 1, 0, 8'h02, 0, 0, 0);
        run(32'h00AB_FFFE, 16'h0003, 1, 1, 8'h01, 1, 0, 0);
        run(32'h1234_5670, 16'h0003, 0, 0, 8'h01, 0, 0, 0);
        run(32'h0000_0100, 16'h0002, 1, 0, 8'h01, 1, 1, 0);
        run(32'h0000_0200, 16'h0004, 1, 0, 8'h02, 0, 0, 1);
        run(32'h0000_0300, 16'h0002, 0, 1, 8'h00, 0, 1, 0);
        for (int j = 0; j < 16; j++) begin
            r = $random(seed);
            run(32'($random(seed)) & ~32'h1, 16'(r[1:0]) + 16'h0001, r[2], r[3], 8'(r[5:4]), r[6], r[7] & r[8], 0);
        end
        final_report();
    end
endmodule
